//--- core/dpc_pkg.sv
/*
 * constants for the debug port configuration and status register block.
 * assumes one clock domain (the port clock) and a plain register port from the
 * port's instruction decoder.
 */
`default_nettype none
package dpc_pkg;
   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [3:0] OFS_REV      = 4'h0;
   localparam logic [3:0] OFS_ERR      = 4'h1;
   localparam logic [3:0] OFS_LINK_CONTROL_A    = 4'h2;
   localparam logic [3:0] OFS_LINK_CONTROL_B    = 4'h3;
   localparam logic [3:0] OFS_RSV_LO   = 4'h4;
   localparam logic [3:0] OFS_RSV_HI   = 4'h6;
   localparam logic [3:0] OFS_KEY      = 4'h7;
   localparam logic [3:0] OFS_SYSTEM_RESET_REQUEST_CODE   = 4'h8;
   localparam logic [3:0] OFS_CLKSEL   = 4'h9;
   localparam logic [3:0] OFS_SYSCTRL  = 4'hA;
   localparam logic [3:0] OFS_SYSSTAT  = 4'hB;
   localparam logic [3:0] OFS_CRC      = 4'hC;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int B_INTER_BYTE_DELAY_ENABLE  = 7;
   localparam int B_PARITY_CHECK_DISABLE   = 5;
   localparam int B_DTD    = 4;
   localparam int B_RSD    = 3;
   localparam int B_NACKD  = 4;
   localparam int B_CCDD   = 3;
   localparam int B_PDIS   = 2;
   localparam int B_UWDONE = 1;
   localparam int B_SYSTEM_CLOCK_REQUEST = 0;
   localparam int B_SYSTEM_RESET_ACTIVE = 5;
   localparam int B_SLEEP  = 4;
   localparam int B_NVMRDY = 3;
   localparam int B_UROWRDY= 2;
   localparam int B_LOCKED = 0;
   localparam int B_UKEY   = 5;
   localparam int B_NKEY   = 4;
   localparam int B_EKEY   = 3;
   // ************************************************************
   // values and reset values
   // ************************************************************
   localparam logic [7:0] RESET_SIG      = 8'h59;
   localparam logic [1:0] CLKSEL_RST     = 2'h3;
   localparam logic [7:0] CTRL_RST       = 8'h00;
   localparam logic [2:0] CRC_RST        = 3'h0;
   localparam logic [3:0] REV_DEFAULT    = 4'h3; // arbitrary value
   localparam logic [2:0] GT_OFF         = 3'h7;
   localparam int IDLE_CHAR_BITS         = 12;
   localparam int IBD_CHARS              = 2;
   localparam int TIMEOUT_CYC            = 65536;
   localparam int GT_MAX_CYC             = 128;
   typedef enum logic [2:0] {
      ERR_NONE = 3'h0, ERR_PARITY = 3'h1, ERR_FRAME = 3'h2, ERR_TIMEOUT = 3'h3,
      ERR_CLKREC = 3'h4, ERR_CONTEND = 3'h7
   } dpc_err_t;
endpackage
`default_nettype wire

//--- core/dpc_regs.sv
/*
 * configuration/status registers of the single pin debug port, with guard
 * time, inter-byte gap, time-out and error signature logic.
 * assumes the port's receiver and transmitter report events as one-cycle
 * pulses and that register access comes only from the port instruction decoder.
 */
// Behaviour
// - only debugger instructions reach these registers
// - physical registers at offsets zero to three
// - access registers four to twelve, four-six reserved
// - read-only revision in upper status nibble
// - error signature loads on error, clears on read
// - codes: none zero, parity one, stop two
// - code three on access layer no response
// - code four on start bit error
// - code seven on line contention
// - two idle characters between multi-byte data bytes
// - first response byte waits guard time only
// - parity disable ignores parity bit
// - time-out after 65536 cycles unless disabled
// - response signature disable suppresses signatures
// - guard time select 128 down to off
// - port disable resets port and configuration
// - nack disable suppresses nack on system reset; here it blocks every nack and system reset blocks nack regardless
// - contention detect disable turns detection off
// - reset signature asserts system reset, others release
`default_nettype none
module dpc_regs
   import dpc_pkg::*;
#(
   parameter int TIMEOUT = TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // register port from the instruction decoder
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // receiver events
   input  wire logic       rx_parity_bad,
   input  wire logic       rx_stop_bad,
   input  wire logic       rx_start_bad,
   input  wire logic       line_contention,
   // access layer handshake
   input  wire logic       acc_req,
   input  wire logic       acc_resp,
   // transmit sequencing
   input  wire logic       tx_turnaround,
   input  wire logic       tx_next_byte,
   input  wire logic       multi_byte_load,
   input  wire logic       resp_sig_want,
   input  wire logic       nack_want,
   output logic            tx_go,
   output logic            resp_sig_send,
   output logic            nack_send,
   // system side status
   input  wire logic       sys_in_reset,
   input  wire logic       sys_sleeping,
   input  wire logic [2:0] key_status,
   input  wire logic       nvm_ready,
   input  wire logic       urow_ready,
   input  wire logic       locked,
   input  wire logic [2:0] crc_status,
   // system side controls
   output logic            sys_reset_req,
   output logic            sys_clock_req,
   output logic            urow_done_pulse,
   output logic      [1:0] clk_freq_sel,
   output logic            port_reset,
   output logic            parity_err_en,
   output logic            contention_en
);
   // ************************************************************
   // storage
   // ************************************************************
   logic [7:0]  link_control_a_r;
   logic [2:0]  link_control_b_r;
   logic [2:0]  err_r;
   logic        system_reset_request_code_r;
   logic        system_reset_active_r;
   logic [1:0]  clksel_r;
   logic        system_clock_request_r;
   logic        pdis_r;
   logic [16:0] to_cnt_r;
   logic        to_busy_r;
   logic [11:0] gap_cnt_r;
   logic        gap_busy_r;
   logic        wr_link_control_b_dis;

   function automatic logic [11:0] gt_cycles(input logic [2:0] sel);
      gt_cycles = (sel == GT_OFF) ? 12'h000 : 12'(GT_MAX_CYC >> sel);
   endfunction

   assign wr_link_control_b_dis = reg_wr && reg_addr == OFS_LINK_CONTROL_B && reg_wdata[B_PDIS];

   // ************************************************************
   // port disable: one-cycle self reset of the port
   // ************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pdis_r <= 1'b0;
      end else begin
         pdis_r <= wr_link_control_b_dis;
      end
   end
   assign port_reset = pdis_r;

   // ************************************************************
   // control registers
   // ************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         link_control_a_r  <= CTRL_RST;
         link_control_b_r  <= 3'h0;
         clksel_r <= CLKSEL_RST;
         system_clock_request_r <= 1'b1;
      end else if (pdis_r) begin
         link_control_a_r  <= CTRL_RST;
         link_control_b_r  <= 3'h0;
         clksel_r <= CLKSEL_RST;
         system_clock_request_r <= 1'b0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            OFS_LINK_CONTROL_A:   link_control_a_r <= reg_wdata & 8'hBF;
            OFS_LINK_CONTROL_B:   link_control_b_r <= reg_wdata[B_NACKD:B_PDIS];
            OFS_CLKSEL:  clksel_r <= reg_wdata[1:0];
            OFS_SYSCTRL: system_clock_request_r <= reg_wdata[B_SYSTEM_CLOCK_REQUEST];
            default: ;
         endcase
      end
   end
   assign sys_clock_req   = system_clock_request_r && !pdis_r;
   assign clk_freq_sel    = clksel_r;
   assign urow_done_pulse = reg_wr && reg_addr == OFS_SYSCTRL && reg_wdata[B_UWDONE] && key_status[2];
   assign parity_err_en   = !link_control_a_r[B_PARITY_CHECK_DISABLE];
   assign contention_en   = !link_control_b_r[1];

   // ************************************************************
   // system reset request
   // ************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         system_reset_request_code_r <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_SYSTEM_RESET_REQUEST_CODE) begin
         system_reset_request_code_r <= (reg_wdata == RESET_SIG);
      end
   end
   assign sys_reset_req = system_reset_request_code_r;

   // sticky system reset flag, cleared on read; a new reset wins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         system_reset_active_r <= 1'b0;
      end else if (sys_in_reset || system_reset_request_code_r) begin
         system_reset_active_r <= 1'b1;
      end else if (reg_rd && reg_addr == OFS_SYSSTAT) begin
         system_reset_active_r <= 1'b0;
      end
   end

   // ************************************************************
   // access layer time-out
   // ************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         to_cnt_r  <= 17'h0;
         to_busy_r <= 1'b0;
      end else if (acc_resp || pdis_r || link_control_a_r[B_DTD]) begin
         to_busy_r <= 1'b0;
         to_cnt_r  <= 17'h0;
      end else if (acc_req) begin
         to_busy_r <= 1'b1;
         to_cnt_r  <= 17'h0;
      end else if (to_busy_r) begin
         to_cnt_r <= to_cnt_r + 17'h1;
         if (to_cnt_r == 17'(TIMEOUT - 1)) begin
            to_busy_r <= 1'b0;
         end
      end
   end
   logic timeout_hit;
   assign timeout_hit = to_busy_r && !acc_resp && !link_control_a_r[B_DTD] && to_cnt_r == 17'(TIMEOUT - 1);

   // ************************************************************
   // error signature
   // ************************************************************
   dpc_err_t err_nxt;
   always_comb begin
      err_nxt = ERR_NONE;
      if (line_contention && contention_en) err_nxt = ERR_CONTEND;
      else if (rx_start_bad)                err_nxt = ERR_CLKREC;
      else if (timeout_hit)                 err_nxt = ERR_TIMEOUT;
      else if (rx_stop_bad)                 err_nxt = ERR_FRAME;
      else if (rx_parity_bad && parity_err_en) err_nxt = ERR_PARITY;
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         err_r <= ERR_NONE;
      end else if (pdis_r) begin
         err_r <= ERR_NONE;
      end else if (err_nxt != ERR_NONE) begin
         err_r <= err_nxt;
      end else if (reg_rd && reg_addr == OFS_ERR) begin
         err_r <= ERR_NONE;
      end
   end

   // ************************************************************
   // guard time before the first response byte, inter-byte gap before later multi-byte data bytes
   // ************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gap_cnt_r  <= 12'h0;
         gap_busy_r <= 1'b0;
      end else if (tx_turnaround) begin
         gap_cnt_r  <= gt_cycles(link_control_a_r[2:0]);
         gap_busy_r <= 1'b1;
      end else if (tx_next_byte && multi_byte_load && link_control_a_r[B_INTER_BYTE_DELAY_ENABLE]) begin
         gap_cnt_r  <= 12'(IBD_CHARS * IDLE_CHAR_BITS);
         gap_busy_r <= 1'b1;
      end else if (gap_busy_r) begin
         if (gap_cnt_r == 12'h0) begin
            gap_busy_r <= 1'b0;
         end else begin
            gap_cnt_r <= gap_cnt_r - 12'h1;
         end
      end
   end
   assign tx_go         = gap_busy_r && gap_cnt_r == 12'h0;
   assign resp_sig_send = resp_sig_want && !link_control_a_r[B_RSD];
   assign nack_send     = nack_want && !link_control_b_r[2] && !sys_in_reset;

   // ************************************************************
   // read mux: debugger port only, no processor path
   // ************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_REV:     reg_rdata <= {REV_DEFAULT, 4'h0};
            OFS_ERR:     reg_rdata <= {5'h0, err_r};
            OFS_LINK_CONTROL_A:   reg_rdata <= link_control_a_r;
            OFS_LINK_CONTROL_B:   reg_rdata <= {3'h0, link_control_b_r, 2'h0};
            OFS_KEY:     reg_rdata <= {2'h0, key_status, 3'h0};
            OFS_SYSTEM_RESET_REQUEST_CODE:  reg_rdata <= {7'h0, system_reset_request_code_r};
            OFS_CLKSEL:  reg_rdata <= {6'h0, clksel_r};
            OFS_SYSCTRL: reg_rdata <= {7'h0, system_clock_request_r};
            OFS_SYSSTAT: reg_rdata <= {2'h0, system_reset_active_r, sys_sleeping, nvm_ready, urow_ready, 1'b0, locked};
            OFS_CRC:     reg_rdata <= {5'h0, crc_status};
            default:     reg_rdata <= 8'h00;
         endcase
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   AST_ERR_CLR: assert property (@(posedge sys_clk) disable iff (rst)
      reg_rd && reg_addr == OFS_ERR && err_nxt == ERR_NONE && !pdis_r |=> err_r == ERR_NONE)
      else $error("error signature not cleared by read");
   AST_PAR: assert property (@(posedge sys_clk) disable iff (rst)
      rx_parity_bad && !link_control_a_r[B_PARITY_CHECK_DISABLE] && !rx_stop_bad && !rx_start_bad && !timeout_hit
      && !(line_contention && contention_en) && !pdis_r |=> err_r == 3'h1)
      else $error("parity error code wrong");
   AST_PARITY_CHECK_DISABLE: assert property (@(posedge sys_clk) disable iff (rst)
      link_control_a_r[B_PARITY_CHECK_DISABLE] && err_r == ERR_NONE && !rx_stop_bad && !rx_start_bad && !timeout_hit && !line_contention
      |=> err_r == ERR_NONE)
      else $error("parity flagged while disabled");
   AST_CONT: assert property (@(posedge sys_clk) disable iff (rst)
      line_contention && !link_control_b_r[1] && !pdis_r |=> err_r == 3'h7)
      else $error("contention code wrong");
   AST_SYSTEM_RESET_REQUEST_CODE: assert property (@(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == OFS_SYSTEM_RESET_REQUEST_CODE |=> sys_reset_req == ($past(reg_wdata) == 8'h59))
      else $error("reset request wrong");
   AST_RSD: assert property (@(posedge sys_clk) disable iff (rst)
      link_control_a_r[B_RSD] |-> !resp_sig_send)
      else $error("signature sent while disabled");
   AST_GT2: assert property (@(posedge sys_clk) disable iff (rst)
      tx_turnaround && link_control_a_r[2:0] == 3'h6 ##1 (!tx_turnaround && !tx_next_byte) [*2] |=> tx_go)
      else $error("guard time of two cycles wrong");
   AST_DIS: assert property (@(posedge sys_clk) disable iff (rst)
      wr_link_control_b_dis |=> ##1 link_control_a_r == 8'h00 && !sys_clock_req)
      else $error("port disable did not clear configuration");
   AST_RSV: assert property (@(posedge sys_clk) disable iff (rst)
      reg_rd && reg_addr >= OFS_RSV_LO && reg_addr <= OFS_RSV_HI |=> reg_rdata == 8'h00)
      else $error("reserved offset not zero");

   // ************************************************************
   // checks on codes, gaps and disables
   // ************************************************************
   AST_REV: assert property (@(posedge sys_clk) disable iff (rst)
      reg_rd && reg_addr == OFS_REV |=> reg_rdata == {REV_DEFAULT, 4'h0})
      else $error("revision field wrong");
   AST_FRAME: assert property (@(posedge sys_clk) disable iff (rst)
      rx_stop_bad && !rx_start_bad && !timeout_hit && !(line_contention && contention_en) && !pdis_r
      |=> err_r == ERR_FRAME)
      else $error("frame error code wrong");
   AST_START: assert property (@(posedge sys_clk) disable iff (rst)
      rx_start_bad && !(line_contention && contention_en) && !pdis_r |=> err_r == ERR_CLKREC)
      else $error("start bit error code wrong");
   AST_TMO: assert property (@(posedge sys_clk) disable iff (rst)
      timeout_hit && !rx_start_bad && !(line_contention && contention_en) && !pdis_r
      |=> err_r == ERR_TIMEOUT)
      else $error("time-out error code wrong");
   AST_DTD: assert property (@(posedge sys_clk) disable iff (rst)
      link_control_a_r[B_DTD] |=> !to_busy_r)
      else $error("time-out watch running while disabled");
   AST_IBD: assert property (@(posedge sys_clk) disable iff (rst)
      tx_next_byte && multi_byte_load && link_control_a_r[B_INTER_BYTE_DELAY_ENABLE] && !tx_turnaround
      |=> gap_busy_r && gap_cnt_r == 12'(IBD_CHARS * IDLE_CHAR_BITS))
      else $error("inter-byte gap length wrong");
   AST_GT_OFF: assert property (@(posedge sys_clk) disable iff (rst)
      tx_turnaround && link_control_a_r[2:0] == GT_OFF |=> tx_go)
      else $error("guard time not off");
   AST_GT_FIRST: assert property (@(posedge sys_clk) disable iff (rst)
      tx_turnaround && link_control_a_r[B_INTER_BYTE_DELAY_ENABLE] && link_control_a_r[2:0] == 3'h6
      |=> gap_cnt_r == 12'h002)
      else $error("first byte waited more than guard time");
   AST_NACK: assert property (@(posedge sys_clk) disable iff (rst)
      link_control_b_r[2] |-> !nack_send)
      else $error("nack sent while disabled");
   AST_CCD: assert property (@(posedge sys_clk) disable iff (rst)
      line_contention && link_control_b_r[1] && err_r == ERR_NONE && !rx_start_bad && !rx_stop_bad
      && !rx_parity_bad && !timeout_hit |=> err_r == ERR_NONE)
      else $error("contention flagged while disabled");
   AST_DIS_ERR: assert property (@(posedge sys_clk) disable iff (rst)
      pdis_r |=> err_r == ERR_NONE && clk_freq_sel == CLKSEL_RST)
      else $error("port disable left state behind");
   AST_PDIS: assert property (@(posedge sys_clk) disable iff (rst)
      wr_link_control_b_dis |=> port_reset)
      else $error("port reset not raised");
   AST_UNMAP: assert property (@(posedge sys_clk) disable iff (rst)
      reg_rd && reg_addr > OFS_CRC |=> reg_rdata == 8'h00)
      else $error("unmapped offset not zero");
   AST_RST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
      sys_reset_req && !(reg_wr && reg_addr == OFS_SYSTEM_RESET_REQUEST_CODE) |=> sys_reset_req)
      else $error("system reset request dropped without write");
endmodule
`default_nettype wire

//--- testbench/dpc_link_model.sv
/*
 * link side model: receiver event pulses and access layer answers.
 * assumes the bench calls its tasks from one process, off the rising edge.
 */
`default_nettype none
module dpc_link_model (
   // clock
   input  wire logic sys_clk,
   // receiver events
   output logic      rx_parity_bad,
   output logic      rx_stop_bad,
   output logic      rx_start_bad,
   output logic      line_contention,
   // access layer handshake
   output logic      acc_req,
   output logic      acc_resp
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // event and answer sequencing
   // ************************************************************
   logic [3:0] ev = 4'h0;
   assign {line_contention, rx_start_bad, rx_stop_bad, rx_parity_bad} = ev;
   initial begin
      acc_req = 1'b0;
      acc_resp = 1'b0;
   end
   // one cycle pulse: 0 parity, 1 stop, 2 start, 3 contention
   task automatic event_pulse(input int k);
      @(negedge sys_clk);
      ev[k] = 1'b1;
      @(negedge sys_clk);
      ev = 4'h0;
   endtask
   // answers after dly cycles, or never; a late answer is how a real bus loses data
   task automatic access(input int dly, input bit answer);
      @(negedge sys_clk);
      acc_req = 1'b1;
      @(negedge sys_clk);
      acc_req = 1'b0;
      repeat (dly) @(negedge sys_clk);
      acc_resp = answer;
      @(negedge sys_clk);
      acc_resp = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
/*
 * self-checking bench for dpc_regs: register reads and writes, error codes,
 * time-out, guard and gap timing, disables. assumes a shortened time-out.
 */
`default_nettype none
module testbench
   import dpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // stimulus and checks
   // ************************************************************
   localparam int TO = 16;
   localparam logic [2:0] ECODE [4] = '{ERR_PARITY, ERR_FRAME, ERR_CLKREC, ERR_CONTEND};
   logic       sys_clk = 1'b0, rst = 1'b1, reg_wr, reg_rd, tx_turnaround, tx_next_byte;
   logic       multi_byte_load, resp_sig_want, nack_want, sys_in_reset, sys_sleeping;
   logic       nvm_ready, urow_ready, locked, rx_parity_bad, rx_stop_bad, rx_start_bad;
   logic       line_contention, acc_req, acc_resp, tx_go, resp_sig_send, nack_send;
   logic       sys_reset_req, sys_clock_req, urow_done_pulse, port_reset, parity_err_en, contention_en;
   logic [1:0] clk_freq_sel;
   logic [2:0] key_status, crc_status;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   int         bad_count = 0, samples_checked = 0, n, c;
   always #4 sys_clk = ~sys_clk;
   dpc_regs #(.TIMEOUT(TO)) i_dut (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .rx_parity_bad, .rx_stop_bad, .rx_start_bad, .line_contention, .acc_req, .acc_resp,
      .tx_turnaround, .tx_next_byte, .multi_byte_load, .resp_sig_want, .nack_want, .tx_go,
      .resp_sig_send, .nack_send, .sys_in_reset, .sys_sleeping, .key_status, .nvm_ready, .urow_ready,
      .locked, .crc_status, .sys_reset_req, .sys_clock_req, .urow_done_pulse, .clk_freq_sel,
      .port_reset, .parity_err_en, .contention_en);
   dpc_link_model i_link (.sys_clk, .rx_parity_bad, .rx_stop_bad, .rx_start_bad, .line_contention,
      .acc_req, .acc_resp);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      chk(reg_rdata, exp);
   endtask
   // cycles from the launching edge until tx_go is seen, bounded
   task automatic gap(input bit turn, output int cnt);
      @(negedge sys_clk);
      tx_turnaround = turn;
      tx_next_byte = !turn;
      @(negedge sys_clk);
      tx_turnaround = 1'b0;
      tx_next_byte = 1'b0;
      cnt = 1;
      while (tx_go !== 1'b1 && cnt < 200) begin
         @(negedge sys_clk);
         cnt++;
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #50us;
      bad_count++;
      results();
   end
   initial begin
      {reg_wr, reg_rd, tx_turnaround, tx_next_byte, multi_byte_load, resp_sig_want, nack_want} = '0;
      {sys_in_reset, sys_sleeping, nvm_ready, urow_ready, locked, key_status, crc_status} = '0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      for (n = 0; n < 16; n++) if (!(n inside {[2:3], [8:10]})) wr(4'(n), 8'hFF);
      for (n = 0; n < 16; n++) rdc(4'(n), n == 0 ? {REV_DEFAULT, 4'h0} : n == 9 ? 8'h03 : n == 10 ? 8'h01 : 8'h00);
      wr(OFS_LINK_CONTROL_A, 8'hFF);
      rdc(OFS_LINK_CONTROL_A, 8'hBF);
      wr(OFS_LINK_CONTROL_B, 8'hFB);
      rdc(OFS_LINK_CONTROL_B, 8'h18);
      chk({6'h0, parity_err_en, contention_en}, 8'h00);
      i_link.event_pulse(0);
      i_link.event_pulse(3);
      rdc(OFS_ERR, 8'h00);
      wr(OFS_LINK_CONTROL_A, 8'h00);
      wr(OFS_LINK_CONTROL_B, 8'h00);
      for (n = 0; n < 4; n++) begin
         i_link.event_pulse(n);
         rdc(OFS_ERR, {5'h0, ECODE[n]});
         rdc(OFS_ERR, 8'h00);
      end
      i_link.access(TO + 4, 1'b0);
      rdc(OFS_ERR, {5'h0, ERR_TIMEOUT});
      i_link.access(TO - 4, 1'b1);
      rdc(OFS_ERR, 8'h00);
      wr(OFS_LINK_CONTROL_A, 8'h10);
      i_link.access(TO + 4, 1'b0);
      rdc(OFS_ERR, 8'h00);
      for (n = 0; n < 8; n++) begin
         wr(OFS_LINK_CONTROL_A, 8'(n));
         gap(1'b1, c);
         chk(8'(c), n == 7 ? 8'h01 : 8'((128 >> n) + 1));
      end
      multi_byte_load = 1'b1;
      wr(OFS_LINK_CONTROL_A, 8'h86);
      gap(1'b1, c);
      chk(8'(c), 8'h03);
      gap(1'b0, c);
      chk(8'(c), 8'(IDLE_CHAR_BITS * IBD_CHARS + 1));
      multi_byte_load = 1'b0;
      {sys_sleeping, nvm_ready, locked, key_status, crc_status} = {3'b111, 3'b101, 3'h5};
      rdc(OFS_KEY, 8'h28);
      rdc(OFS_SYSSTAT, 8'h19);
      rdc(OFS_CRC, 8'h05);
      resp_sig_want = 1'b1;
      nack_want = 1'b1;
      wr(OFS_LINK_CONTROL_A, 8'h00);
      chk({6'h0, resp_sig_send, nack_send}, 8'h03);
      wr(OFS_LINK_CONTROL_A, 8'h08);
      wr(OFS_LINK_CONTROL_B, 8'h10);
      chk({6'h0, resp_sig_send, nack_send}, 8'h00);
      wr(OFS_LINK_CONTROL_B, 8'h00);
      sys_in_reset = 1'b1;
      @(negedge sys_clk);
      chk({7'h0, nack_send}, 8'h00);
      sys_in_reset = 1'b0;
      rdc(OFS_SYSSTAT, 8'h39);
      rdc(OFS_SYSSTAT, 8'h19);
      wr(OFS_SYSTEM_RESET_REQUEST_CODE, RESET_SIG);
      chk({7'h0, sys_reset_req}, 8'h01);
      rdc(OFS_SYSTEM_RESET_REQUEST_CODE, 8'h01);
      wr(OFS_SYSTEM_RESET_REQUEST_CODE, 8'h58);
      chk({7'h0, sys_reset_req}, 8'h00);
      wr(OFS_LINK_CONTROL_A, 8'h3F);
      wr(OFS_CLKSEL, 8'h01);
      chk({6'h0, clk_freq_sel}, 8'h01);
      @(negedge sys_clk);
      {reg_addr, reg_wdata, reg_wr} = {OFS_SYSCTRL, 8'h03, 1'b1};
      #1 chk({7'h0, urow_done_pulse}, 8'h01);
      @(negedge sys_clk);
      reg_wr = 1'b0;
      i_link.event_pulse(1);
      wr(OFS_LINK_CONTROL_B, 8'h04);
      chk({7'h0, port_reset}, 8'h01);
      rdc(OFS_LINK_CONTROL_A, 8'h00);
      rdc(OFS_LINK_CONTROL_B, 8'h00);
      rdc(OFS_CLKSEL, 8'h03);
      rdc(OFS_ERR, 8'h00);
      chk({7'h0, sys_clock_req}, 8'h00);
      results();
   end
endmodule
`default_nettype wire
